// [ctrl_regs_device.sv]
// device end: general control registers behind the spi frame
`timescale 1ns/100ps
module ctrl_regs_device
   import regs_pkg::*;
(
   input  wire logic       aclk,                 // system clock
   input  wire logic       aresetn,              // synchronous reset, active low
   spi_link_if.device      link,                 // spi pins
   input  wire logic       restart_enter,        // pulse, restart mode entered
   input  wire logic       overtemp_event,       // pulse, overtemperature
   input  wire logic       main_overvoltage,     // level, main regulator overvoltage
   input  wire logic       supply_undervoltage,  // level, supply undervoltage
   input  wire logic       failure_active,       // level, failure status set
   input  wire logic       in_stop_mode,         // level, state machine in stop
   output logic [1:0]      mode_request,         // requested operating mode
   output logic            soft_reset_req,       // pulse, soft reset requested
   output logic            reset_output_pulse,   // high pulls reset output low
   output logic            aux_regulator_on,     // third regulator enabled
   output logic            aux_voltage_select,   // 1 lower alternate voltage
   output logic [1:0]      second_regulator_control, // second regulator mode
   output logic            main_ov_flag,         // overvoltage seen
   output logic            main_ov_react,        // overvoltage restart request
   output logic [1:0]      main_reset_threshold_select, // 0 highest
   output logic            failure_outputs,      // failure outputs active
   output logic            aux_load_sharing_enable, // load sharing
   output logic            aux_load_sharing_in_stop, // load sharing in stop
   output logic            wd_first_fail_select  // 1 react on first failure
);
   logic [7:0]  ms_q;
   logic [7:0]  hw_q;
   logic        sclk_q;
   logic [15:0] sh_q;
   logic [4:0]  cnt_q;
   logic [7:0]  tx_q;
   logic        miso_q;
   logic        done_q;
   logic        wr_ms;
   logic        wr_hw;
   logic [7:0]  wdat;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        stop_to_sleep;

   function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [7:0] ms,
                                           input logic [7:0] hw);
      read_reg = (a == ADDR_MODE_SUPPLY) ? ms :
                 (a == ADDR_HW_CONFIG)   ? (hw & ~RSVD_MASK_HW) : 8'h00;
   endfunction

   // mode field decode, shared by the request and the reset-output pulse
   function automatic logic is_soft_reset(input logic [7:0] d);
      is_soft_reset = (d[7:6] == MODE_SOFT_RESET);
   endfunction

   assign sclk_rise = link.sclk & ~sclk_q;
   assign sclk_fall = ~link.sclk & sclk_q;

   // shift in on rising edges, frame bit 15 arrives first
   // cs_n high drops a cut frame; no write lands from a partial frame
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_q <= 1'b0;
         sh_q   <= 16'h0000;
         cnt_q  <= 5'h00;
         done_q <= 1'b0;
      end else begin
         sclk_q <= link.sclk;
         done_q <= 1'b0;
         if (link.cs_n) begin
            cnt_q <= 5'h00;
         end else if (sclk_rise && cnt_q < 5'(FRAME_W)) begin
            sh_q  <= {sh_q[14:0], link.mosi};
            cnt_q <= cnt_q + 5'h01;
            done_q <= (cnt_q == 5'(FRAME_W - 1));
         end
      end
   end

   // frame bit 15 first: sh_q[15:8] = addr+access, sh_q[7:0] = data
   // frame order: bits 15..9 address, 8 access, 7..0 data d7..d0
   assign wdat  = sh_q[7:0];
   assign wr_ms = done_q && sh_q[8 + FRAME_RW_BIT - 7] && sh_q[15:9] == ADDR_MODE_SUPPLY;
   assign wr_hw = done_q && sh_q[8] && sh_q[15:9] == ADDR_HW_CONFIG;
   // stop is seen either from the state machine or from the last request
   assign stop_to_sleep = (in_stop_mode || ms_q[7:6] == MODE_STOP) && wdat[7:6] == MODE_SLEEP;

   // answer: old content shifted out during the data byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_q   <= 8'h00;
         miso_q <= 1'b0;
      end else if (link.cs_n) begin
         miso_q <= 1'b0;
      end else if (sclk_rise && cnt_q == 5'h07) begin
         // address complete; capture before any write lands
         // seven address bits are in; mosi now carries the access bit
         tx_q <= read_reg(sh_q[6:0], ms_q, hw_q);
      end else if (sclk_fall && cnt_q >= 5'h08 && cnt_q < 5'(FRAME_W)) begin
         miso_q <= tx_q[7];
         tx_q   <= {tx_q[6:0], 1'b0};
      end
   end
   assign link.miso = miso_q;

   // mode and supply control register
   always_ff @(posedge aclk) begin
      // soft reset clears the whole register, so it shares the power-on branch
      if (!aresetn || soft_reset_req) begin
         ms_q <= POR_MODE_SUPPLY;
      end else if (restart_enter) begin
         // restart outranks a write landing in the same cycle
         ms_q <= ms_q & RESTART_KEEP_MS;
      end else begin
         if (wr_ms) begin
            ms_q <= wdat;
            if (stop_to_sleep) begin
               ms_q[7:6] <= ms_q[7:6];
            end
         end
         // hardware wins over a write landing in the same cycle
         if (overtemp_event) begin
            ms_q[4:3] <= SEC_OFF;
         end
      end
   end

   // hardware configuration register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hw_q <= POR_HW_CONFIG;
      end else if (soft_reset_req) begin
         // soft reset outranks restart; both outrank a write
         hw_q <= hw_q & SOFT_KEEP_HW;
      end else if (restart_enter) begin
         hw_q <= hw_q & RESTART_KEEP_HW;
      end else if (wr_hw) begin
         hw_q <= wdat & ~RSVD_MASK_HW;
      end
   end

   // soft reset request leaves the register cleared next cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         soft_reset_req     <= 1'b0;
         reset_output_pulse <= 1'b0;
      end else begin
         // suppress bit is read as it stood before the reset clears the rest
         soft_reset_req     <= wr_ms && is_soft_reset(wdat);
         reset_output_pulse <= wr_ms && is_soft_reset(wdat)
                               && !hw_q[SOFT_SUPP_BIT];
      end
   end

   // decoded outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_request                <= MODE_NORMAL;
         aux_regulator_on            <= 1'b0;
         aux_voltage_select          <= 1'b0;
         second_regulator_control    <= SEC_OFF;
         main_ov_flag                <= 1'b0;
         main_ov_react               <= 1'b0;
         main_reset_threshold_select <= 2'h0;
         failure_outputs             <= 1'b0;
         aux_load_sharing_enable     <= 1'b0;
         aux_load_sharing_in_stop    <= 1'b0;
         wd_first_fail_select        <= 1'b0;
      end else begin
         // every output one flop behind its register bits or status inputs
         mode_request             <= ms_q[7:6];
         aux_regulator_on         <= ms_q[AUX_EN_BIT] &&
                                     (!supply_undervoltage || hw_q[AUX_UV_KEEP_BIT]);
         aux_voltage_select       <= hw_q[AUX_VSEL_BIT];
         second_regulator_control <= ms_q[4:3];
         main_ov_flag             <= main_overvoltage;
         main_ov_react            <= main_overvoltage && ms_q[OV_REACT_BIT];
         main_reset_threshold_select <= ms_q[1:0];
         // failure status keeps the outputs on when software clears its bit
         failure_outputs          <= hw_q[FO_SW_BIT] || failure_active;
         aux_load_sharing_enable  <= hw_q[AUX_LS_BIT];
         aux_load_sharing_in_stop <= hw_q[AUX_LS_BIT] && hw_q[AUX_LS_STOP_BIT] && in_stop_mode;
         wd_first_fail_select     <= hw_q[WD_CFG_BIT];
      end
   end
endmodule

// [regs_pkg.sv]
// shared constants for the general control register bank and its host
package regs_pkg;
   localparam int          FRAME_W           = 16;
   localparam int          ADDR_W            = 7;
   localparam logic [6:0]  ADDR_MODE_SUPPLY  = 7'h01;
   localparam logic [6:0]  ADDR_HW_CONFIG    = 7'h02;
   localparam logic [7:0]  POR_MODE_SUPPLY   = 8'h00;
   localparam logic [7:0]  POR_HW_CONFIG     = 8'h00;
   // bits kept across a soft reset in the hardware configuration register
   localparam logic [7:0]  SOFT_KEEP_HW      = 8'h88;
   // restart keeps: mode_supply 00x0 00xx, hw_config xx0x x00x
   localparam logic [7:0]  RESTART_KEEP_MS   = 8'h23;
   localparam logic [7:0]  RESTART_KEEP_HW   = 8'hD9;
   localparam logic [7:0]  RSVD_MASK_HW      = 8'h04;
   localparam int          FRAME_RW_BIT      = 7;
   localparam int          MODE_LSB          = 6;
   localparam int          AUX_EN_BIT        = 5;
   localparam int          SEC_LSB           = 3;
   localparam int          OV_REACT_BIT      = 2;
   localparam int          SOFT_SUPP_BIT     = 6;
   localparam int          FO_SW_BIT         = 5;
   localparam int          AUX_UV_KEEP_BIT   = 4;
   localparam int          AUX_LS_BIT        = 3;
   localparam int          AUX_LS_STOP_BIT   = 1;
   localparam int          WD_CFG_BIT        = 0;
   localparam int          AUX_VSEL_BIT      = 7;
   localparam logic [1:0]  MODE_NORMAL       = 2'h0;
   localparam logic [1:0]  MODE_SLEEP        = 2'h1;
   localparam logic [1:0]  MODE_STOP         = 2'h2;
   localparam logic [1:0]  MODE_SOFT_RESET   = 2'h3;
   localparam logic [1:0]  SEC_OFF           = 2'h0;
   localparam logic [1:0]  SEC_NORMAL        = 2'h1;
   localparam logic [1:0]  SEC_NORM_STOP     = 2'h2;
   localparam logic [1:0]  SEC_ALWAYS        = 2'h3;
   localparam int          SCLK_DIV          = 4;
   // host register map for software, AXI4-Lite byte addresses
   localparam logic [3:0]  HOST_CMD_OFS      = 4'h0;
   localparam logic [3:0]  HOST_STAT_OFS     = 4'h4;
endpackage

// [sbc_link_properties.sv]
// checks on the spi link between the two ends
`timescale 1ns/100ps
module sbc_link_properties (
   input wire logic aclk,    // system clock
   input wire logic aresetn, // sync reset, active low
   input wire logic sclk,    // shift clock
   input wire logic cs_n,    // frame select, active low
   input wire logic mosi,    // host to device
   input wire logic miso     // device to host
);
   logic       sclk_q; // shift clock one cycle back
   logic [4:0] bits_q; // rising shift edges in this frame
   always_ff @(posedge aclk) begin
      sclk_q <= aresetn ? sclk : 1'b0;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || cs_n) begin
         bits_q <= 5'h00;
      end else if (sclk && !sclk_q) begin
         bits_q <= bits_q + 5'h01;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   still_clk_a: assert property (cs_n && $past(cs_n) |-> $stable(sclk))
      else $error("shift clock moved between frames");
   frame_len_a: assert property ($rose(cs_n) |-> bits_q == 5'h10)
      else $error("frame not sixteen bits");
   half_per_a: assert property (!cs_n && $changed(sclk) |=> $stable(sclk) [*3])
      else $error("shift clock half period short");
   mosi_hold_a: assert property (!cs_n && $rose(sclk) |-> $stable(mosi))
      else $error("mosi moved at sampling edge");
   miso_edge_a: assert property (!cs_n && !$past(cs_n) && $changed(miso) |-> !sclk)
      else $error("miso moved while shift clock high");
   clk_start_a: assert property ($fell(cs_n) |-> ##[1:8] $rose(sclk))
      else $error("no shift clock after select");
   frame_end_a: assert property ($fell(cs_n) |-> ##[16:200] $rose(cs_n))
      else $error("frame never closed");
   reset_idle_a: assert property ($rose(aresetn) |-> cs_n && !sclk)
      else $error("link not idle after reset");
   cover property ($rose(cs_n));
   cover property (!cs_n && $rose(sclk) && bits_q == 5'h07 && mosi);
   cover property (!cs_n && $changed(miso));
endmodule

// [spi_host_ctrl.sv]
// host end: axi4-lite commanded spi master for the register bank
`timescale 1ns/100ps
module spi_host_ctrl
   import regs_pkg::*;
(
   input  wire logic        aclk,       // system clock
   input  wire logic        aresetn,    // synchronous reset, active low
   input  wire logic [3:0]  awaddr,     // write address
   input  wire logic        awvalid,    // write address valid
   output logic             awready,    // write address ready
   input  wire logic [31:0] wdata,      // write data
   input  wire logic [3:0]  wstrb,      // byte strobes
   input  wire logic        wvalid,     // write data valid
   output logic             wready,     // write data ready
   output logic [1:0]       bresp,      // write response
   output logic             bvalid,     // write response valid
   input  wire logic        bready,     // write response ready
   input  wire logic [3:0]  araddr,     // read address
   input  wire logic        arvalid,    // read address valid
   output logic             arready,    // read address ready
   output logic [31:0]      rdata,      // read data
   output logic [1:0]       rresp,      // read response
   output logic             rvalid,     // read data valid
   input  wire logic        rready,     // read data ready
   spi_link_if.host         link        // spi pins
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE = 3'b100
   } st_e;
   st_e         st_q;
   logic        aw_q, w_q;
   logic [3:0]  awa_q;
   logic [31:0] wd_q;
   logic [15:0] tx_q;
   logic [7:0]  rx_q;
   logic [4:0]  bit_q;
   logic [1:0]  div_q;
   logic        busy;
   logic        sclk_q, cs_n_q;
   logic        go;
   logic        bad;

   // command word: [6:0] address, [7] write, [15:8] data; write starts a frame
   assign busy = (st_q != ST_IDLE);
   assign bad  = (awa_q != HOST_CMD_OFS);
   assign go   = aw_q && w_q && !bvalid && !busy;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 4'h0; wd_q <= 32'h0;
         awready <= 1'b0; wready <= 1'b0; bvalid <= 1'b0; bresp <= 2'h0;
      end else begin
         awready <= !aw_q && awvalid && !awready;
         wready  <= !w_q && wvalid && !wready;
         if (awready && awvalid) begin
            aw_q <= 1'b1;
            awa_q <= awaddr;
         end
         if (wready && wvalid) begin
            w_q <= 1'b1;
            wd_q <= wdata;
         end
         if (aw_q && w_q && !bvalid && (bad || !busy)) begin
            aw_q <= 1'b0; w_q <= 1'b0; bvalid <= 1'b1;
            bresp <= bad ? 2'h2 : 2'h0;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0; rvalid <= 1'b0; rdata <= 32'h0; rresp <= 2'h0;
      end else begin
         arready <= arvalid && !arready && !rvalid;
         if (arready && arvalid) begin
            rvalid <= 1'b1;
            rresp  <= (araddr == HOST_STAT_OFS || araddr == HOST_CMD_OFS) ? 2'h0 : 2'h2;
            rdata  <= (araddr == HOST_STAT_OFS) ? {23'h0, busy, rx_q} :
                      (araddr == HOST_CMD_OFS)  ? {16'h0, tx_q} : 32'h0;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // frame engine; half sclk period every SCLK_DIV clocks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= ST_IDLE; tx_q <= 16'h0; rx_q <= 8'h0; bit_q <= 5'h0;
         div_q <= 2'h0; sclk_q <= 1'b0; cs_n_q <= 1'b1;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (go && !bad) begin
                  // tx_q bit 0 first: address msb..., access bit, data d7..d0
                  tx_q  <= wd_q[15:0];
                  bit_q <= 5'h0; div_q <= 2'h0; cs_n_q <= 1'b0;
                  st_q  <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               div_q <= div_q + 2'h1;
               if (div_q == 2'(SCLK_DIV - 1)) begin
                  sclk_q <= !sclk_q;
                  if (sclk_q) begin
                     tx_q  <= {1'b0, tx_q[15:1]};
                     bit_q <= bit_q + 5'h1;
                     if (bit_q == 5'(FRAME_W - 1))
                        st_q <= ST_DONE;
                  end else if (bit_q >= 5'h8) begin
                     rx_q <= {rx_q[6:0], link.miso};
                  end
               end
            end
            ST_DONE: begin
               cs_n_q <= 1'b1;
               st_q   <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   assign link.sclk = sclk_q;
   assign link.cs_n = cs_n_q;
   assign link.mosi = tx_q[0];
endmodule

// [spi_link_if.sv]
// spi link joining the register bank and its host
`timescale 1ns/100ps
interface spi_link_if;
   logic sclk;   // shift clock, sampled by the device
   logic cs_n;   // frame select, active low
   logic mosi;   // host to device
   logic miso;   // device to host
   modport device (input sclk, input cs_n, input mosi, output miso);
   modport host   (output sclk, output cs_n, output mosi, input miso);
endinterface

// [test_sbc_general_control_regs.sv]
// bench: axi4-lite host end drives the register bank over spi
`timescale 1ns/100ps
module test_sbc_general_control_regs;
   import regs_pkg::*;
   typedef struct packed {
      logic [6:0] a;
      logic       w;
      logic [7:0] d;
      logic [7:0] ans;
      logic [7:0] ms;
      logic [7:0] hw;
   } row_s;
   logic        aclk = 1'b0, aresetn = 1'b0, restart_enter = 1'b0, overtemp_event = 1'b0;
   logic        main_overvoltage = 1'b0, supply_undervoltage = 1'b0, failure_active = 1'b0;
   logic        in_stop_mode = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, saw_ro = 1'b0, saw_sr = 1'b0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [1:0]  bresp, rresp, mode_request, second_regulator_control, main_reset_threshold_select;
   logic        awready, wready, bvalid, arready, rvalid, soft_reset_req, reset_output_pulse;
   logic        aux_regulator_on, aux_voltage_select, main_ov_flag, main_ov_react, failure_outputs;
   logic        aux_load_sharing_enable, aux_load_sharing_in_stop, wd_first_fail_select;
   logic [15:0] wire_q = 16'h0000;
   logic [11:0] outs;
   int          mismatches = 0, num_checks = 0;
   row_s        rows [8] = '{
      '{7'h01, 1'b1, 8'h3F, 8'h00, 8'h3F, 8'h00},
      '{7'h01, 1'b0, 8'hA5, 8'h3F, 8'h3F, 8'h00},
      '{7'h02, 1'b1, 8'hFF, 8'h00, 8'h3F, 8'hFB},
      '{7'h02, 1'b0, 8'h00, 8'hFB, 8'h3F, 8'hFB},
      '{7'h01, 1'b1, 8'h55, 8'h3F, 8'h55, 8'hFB},
      '{7'h01, 1'b1, 8'h8A, 8'h55, 8'h8A, 8'hFB},
      '{7'h7F, 1'b0, 8'h00, 8'h00, 8'h8A, 8'hFB},
      '{7'h7F, 1'b1, 8'hFF, 8'h00, 8'h8A, 8'hFB}};
   spi_link_if spi_link_if_inst ();
   ctrl_regs_device ctrl_regs_device_inst (.aclk, .aresetn, .link(spi_link_if_inst),
      .restart_enter, .overtemp_event, .main_overvoltage, .supply_undervoltage, .failure_active,
      .in_stop_mode, .mode_request, .soft_reset_req, .reset_output_pulse, .aux_regulator_on,
      .aux_voltage_select, .second_regulator_control, .main_ov_flag, .main_ov_react,
      .main_reset_threshold_select, .failure_outputs, .aux_load_sharing_enable,
      .aux_load_sharing_in_stop, .wd_first_fail_select);
   spi_host_ctrl spi_host_ctrl_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .link(spi_link_if_inst));
   sbc_link_properties sbc_link_properties_inst (.aclk, .aresetn, .sclk(spi_link_if_inst.sclk),
      .cs_n(spi_link_if_inst.cs_n), .mosi(spi_link_if_inst.mosi), .miso(spi_link_if_inst.miso));
   assign outs = {mode_request, aux_regulator_on, aux_voltage_select, second_regulator_control,
      main_reset_threshold_select, failure_outputs, aux_load_sharing_enable,
      aux_load_sharing_in_stop, wd_first_fail_select};
   always #25 aclk = ~aclk;
   always @(posedge spi_link_if_inst.sclk) begin
      if (!spi_link_if_inst.cs_n) wire_q <= {wire_q[14:0], spi_link_if_inst.mosi};
   end
   // pulses are short, so latch them for a later look
   always @(posedge aclk) begin
      if (reset_output_pulse === 1'b1) saw_ro <= 1'b1;
      if (soft_reset_req === 1'b1) saw_sr <= 1'b1;
   end
   function automatic logic [11:0] exp_out(input logic [7:0] ms, input logic [7:0] hw);
      logic aux;
      aux = ms[5] && !(supply_undervoltage && !hw[4]);
      return {ms[7:6], aux, hw[7], ms[4:3], ms[1:0], hw[5] || failure_active, hw[3],
              hw[3] && hw[1] && in_stop_mode, hw[0]};
   endfunction
   task automatic conclude();
      if (mismatches == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic stall();
      mismatches++;
      conclude();
   endtask
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_outs(input logic [7:0] ms, input logic [7:0] hw);
      num_checks++;
      if (outs !== exp_out(ms, hw)) begin
         mismatches++;
         $display("unexpected outputs at %0t: got %h expected %h", $time, outs, exp_out(ms, hw));
      end
   endtask
   task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= {3{wr}};
      {arvalid, rready} <= {2{!wr}};
      do begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while ((wr ? bvalid : rvalid) !== 1'b1 && n < 500);
      {bready, rready} <= 2'b00;
      q = rdata;
      r = wr ? bresp : rresp;
      if (n >= 500) stall();
   endtask
   task automatic frame(input logic [6:0] a, input logic w, input logic [7:0] d,
                        input logic [7:0] e);
      logic [31:0] s;
      logic [15:0] c;
      logic [1:0]  r;
      int          n;
      // command word goes out lsb first, the wire wants address msb first
      c = {<<{a, w, d}};
      axi(1'b1, HOST_CMD_OFS, {16'h0000, c}, s, r);
      s = 32'h0000_0100;
      for (n = 0; s[8] !== 1'b0 && n < 99; n++) axi(1'b0, HOST_STAT_OFS, 32'h0, s, r);
      if (n >= 99) stall();
      chk_val({24'h0, s[7:0]}, {24'h0, e});
      chk_val({16'h0, wire_q}, {16'h0, a, w, d});
      repeat (4) @(posedge aclk);
   endtask
   initial begin
      logic [31:0] s;
      logic [1:0]  r;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk_outs(8'h00, 8'h00);
      foreach (rows[i]) begin
         frame(rows[i].a, rows[i].w, rows[i].d, rows[i].ans);
         chk_outs(rows[i].ms, rows[i].hw);
      end
      in_stop_mode <= 1'b1;
      frame(7'h01, 1'b1, 8'h5A, 8'h8A);
      chk_outs(8'h9A, 8'hFB);
      in_stop_mode <= 1'b0;
      main_overvoltage <= 1'b1;
      repeat (3) @(posedge aclk);
      chk_val({30'h0, main_ov_flag, main_ov_react}, 32'h0000_0002);
      frame(7'h01, 1'b1, 8'h1E, 8'h9A);
      chk_val({30'h0, main_ov_flag, main_ov_react}, 32'h0000_0003);
      main_overvoltage <= 1'b0;
      overtemp_event <= 1'b1;
      @(posedge aclk);
      overtemp_event <= 1'b0;
      repeat (2) @(posedge aclk);
      chk_outs(8'h06, 8'hFB);
      frame(7'h01, 1'b1, 8'h7F, 8'h06);
      restart_enter <= 1'b1;
      @(posedge aclk);
      restart_enter <= 1'b0;
      repeat (2) @(posedge aclk);
      chk_outs(8'h23, 8'hD9);
      failure_active <= 1'b1;
      frame(7'h02, 1'b1, 8'hF9, 8'hD9);
      frame(7'h02, 1'b1, 8'hD9, 8'hF9);
      chk_outs(8'h23, 8'hD9);
      failure_active <= 1'b0;
      supply_undervoltage <= 1'b1;
      repeat (2) @(posedge aclk);
      chk_outs(8'h23, 8'hD9);
      frame(7'h02, 1'b1, 8'hC9, 8'hD9);
      chk_outs(8'h23, 8'hC9);
      supply_undervoltage <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         frame(7'h02, 1'b1, k ? 8'hC8 : 8'h89, k ? 8'h88 : 8'hC9);
         saw_ro <= 1'b0;
         saw_sr <= 1'b0;
         frame(7'h01, 1'b1, 8'hC0, k ? 8'h00 : 8'h23);
         chk_val({30'h0, saw_sr, saw_ro}, {30'h0, 1'b1, k == 0});
         frame(7'h02, 1'b0, 8'h00, 8'h88);
         chk_outs(8'h00, 8'h88);
      end
      axi(1'b0, 4'h8, 32'h0, s, r);
      chk_val({30'h0, r}, 32'h0000_0002);
      axi(1'b1, 4'hC, 32'h0, s, r);
      chk_val({30'h0, r}, 32'h0000_0002);
      frame(7'h01, 1'b1, 8'h3F, 8'h00);
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      frame(7'h01, 1'b0, 8'h00, 8'h00);
      frame(7'h02, 1'b0, 8'h00, 8'h00);
      conclude();
   end
endmodule
